// ===== rtl/ssc_top.sv
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ssc_cfg.svh"
module ssc_top #(
    parameter logic [15:0] SATNAV_CODES = 16'h0200, // source codes using satellite time
    parameter logic [15:0] DUAL_CODES = 16'h0600 // dual-source safety codes
) (
    input wire logic pclk, // 100 MHz clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb write
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input wire logic src_valid, // sync source delivers valid time
    input wire logic time_stb, // received time strobe
    input wire ssc_pkg::ssc_time_t ext_time, // received time
    input wire ssc_pkg::ssc_time_t int_time, // internal clock time
    input wire logic ext_chg_stb, // source changeover announcement
    input wire logic int_chg_stb, // internal changeover time reached
    output logic clock_load, // load internal clock pulse
    output ssc_pkg::ssc_time_t clock_load_time, // value to load
    output logic dst_apply, // perform changeover pulse
    output logic dst_internal, // internal changeover times in force
    output logic clock_valid, // clock status valid
    output logic status_dash, // show dash status indicator
    output logic leap_error, // leap error status
    output ssc_pkg::ssc_src_t display_id, // identifier of selected source
    output logic display_err, // show error instead of identifier
    output logic master_reset, // system master reset pulse
    output logic irq // interrupt, active high level
);
    import ssc_pkg::*;

    // a literal cannot be bit-selected, so the code table is held as a constant
    localparam logic [15:0] VALID_CODES = `SSC_VALID_CODES;

    logic [`SSC_SETTING_W-1:0] setting_r, setting_nxt;
    logic [`SSC_INT_W-1:0] int_stat_r, int_stat_nxt, int_mask_r, int_mask_nxt, int_set;
    logic [31:0] prdata_nxt, status_word;
    logic pready_nxt, pslverr_nxt, irq_nxt;
    logic mrst_nxt, valid_nxt, leap_err_nxt, hold_r, hold_nxt, disp_err_nxt;
    logic wr_acc, rd_acc, mapped;
    logic load_stb, leap_stb, lost_stb, is_dual, is_satnav;
    ssc_src_t src_sel, disp_nxt;

    // a write is taken in the access cycle while pready stands high, a read in the setup cycle
    assign wr_acc = psel && penable && pready && pwrite;
    assign rd_acc = psel && !penable && !pwrite;
    assign mapped = (paddr == `SSC_OFF_SETTING) || (paddr == `SSC_OFF_STATUS) ||
                    (paddr == `SSC_OFF_INT_STAT) || (paddr == `SSC_OFF_INT_MASK);
    assign src_sel = setting_r[`SSC_SRC_MSB:`SSC_SRC_LSB];
    assign is_dual = DUAL_CODES[src_sel];
    assign is_satnav = SATNAV_CODES[src_sel];

    // live status word, sampled into prdata in the setup cycle
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`SSC_ST_VALID] = clock_valid;
        status_word[`SSC_ST_LEAP_ERR] = leap_error;
        status_word[`SSC_ST_DST_INT] = dst_internal;
        status_word[`SSC_ST_DISP_ERR] = display_err;
        status_word[`SSC_ST_SRC_MSB:`SSC_ST_SRC_LSB] = display_id;
        status_word[`SSC_ST_SRC_OK] = src_valid;
    end

    // apb answer: one access cycle, read data prepared during setup
    always_comb begin
        pready_nxt = psel && !penable;
        pslverr_nxt = psel && !penable && !mapped;
        prdata_nxt = 32'h0000_0000;
        if (rd_acc) begin
            unique case (paddr)
                `SSC_OFF_SETTING: prdata_nxt = {{(32-`SSC_SETTING_W){1'b0}}, setting_r};
                `SSC_OFF_STATUS: prdata_nxt = status_word;
                `SSC_OFF_INT_STAT: prdata_nxt = {{(32-`SSC_INT_W){1'b0}}, int_stat_r};
                `SSC_OFF_INT_MASK: prdata_nxt = {{(32-`SSC_INT_W){1'b0}}, int_mask_r};
                default: prdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= pready_nxt;
            pslverr <= pslverr_nxt;
            prdata <= prdata_nxt;
        end
    end

    // setting byte and the master reset that a new source code brings
    always_comb begin
        setting_nxt = setting_r;
        mrst_nxt = 1'b0;
        if (wr_acc && paddr == `SSC_OFF_SETTING) begin
            setting_nxt = pwdata[`SSC_SETTING_W-1:0];
            // rewriting the same code leaves the system running
            mrst_nxt = pwdata[`SSC_SRC_MSB:`SSC_SRC_LSB] != src_sel;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setting_r <= `SSC_SETTING_RST;
            master_reset <= 1'b0;
        end else begin
            setting_r <= setting_nxt;
            master_reset <= mrst_nxt;
        end
    end

    // identifier shown for the selected source, error for codes without a mode
    always_comb begin
        disp_nxt = src_sel;
        disp_err_nxt = !VALID_CODES[src_sel];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            display_id <= 4'h0;
            display_err <= 1'b0;
        end else begin
            display_id <= disp_nxt;
            display_err <= disp_err_nxt;
        end
    end

    ssc_leap u_leap (
        .pclk(pclk),
        .presetn(presetn),
        .restart(master_reset),
        .time_stb(time_stb),
        .src_valid(src_valid),
        .leap_en(setting_r[`SSC_BIT_LEAP_EN]),
        .ext_time(ext_time),
        .int_time(int_time),
        .load_stb(load_stb),
        .load_time(clock_load_time),
        .leap_stb(leap_stb),
        .lost_stb(lost_stb)
    );

    ssc_dst u_dst (
        .pclk(pclk),
        .presetn(presetn),
        .policy(setting_r[`SSC_BIT_POLICY]),
        .override(setting_r[`SSC_BIT_OVERRIDE]),
        .satnav(is_satnav),
        .src_valid(src_valid),
        .ext_chg_stb(ext_chg_stb),
        .int_chg_stb(int_chg_stb),
        .use_internal(dst_internal),
        .apply_stb(dst_apply)
    );

    assign clock_load = load_stb;

    // clock status: a leap holds it invalid until the source is lost and regained cleanly
    always_comb begin
        hold_nxt = hold_r;
        if (master_reset || lost_stb) begin
            hold_nxt = 1'b0;
        end
        if (leap_stb) begin
            hold_nxt = 1'b1;
        end
        valid_nxt = !master_reset && src_valid && !hold_nxt && (clock_valid || load_stb);
        leap_err_nxt = !master_reset && (leap_error || (leap_stb && is_dual));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_r <= 1'b0;
            clock_valid <= 1'b0;
            status_dash <= 1'b1;
            leap_error <= 1'b0;
        end else begin
            hold_r <= hold_nxt;
            clock_valid <= valid_nxt;
            status_dash <= !valid_nxt;
            leap_error <= leap_err_nxt;
        end
    end

    // sticky events, write one to clear; a new event wins over a clear
    always_comb begin
        int_set = '0;
        int_set[`SSC_INT_LEAP] = leap_stb;
        int_set[`SSC_INT_MRST] = master_reset;
        int_set[`SSC_INT_LOST] = lost_stb;
        int_set[`SSC_INT_DST] = dst_apply;
        int_stat_nxt = int_stat_r;
        int_mask_nxt = int_mask_r;
        if (wr_acc && paddr == `SSC_OFF_INT_STAT) begin
            int_stat_nxt = int_stat_r & ~pwdata[`SSC_INT_W-1:0];
        end
        if (wr_acc && paddr == `SSC_OFF_INT_MASK) begin
            int_mask_nxt = pwdata[`SSC_INT_W-1:0];
        end
        int_stat_nxt = int_stat_nxt | int_set;
        irq_nxt = |(int_stat_nxt & int_mask_nxt);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_r <= `SSC_INT_RST;
            int_mask_r <= `SSC_INT_RST;
            irq <= 1'b0;
        end else begin
            int_stat_r <= int_stat_nxt;
            int_mask_r <= int_mask_nxt;
            irq <= irq_nxt;
        end
    end

    // a write of a different source code
    sequence s_src_change;
        wr_acc && paddr == `SSC_OFF_SETTING && pwdata[`SSC_SRC_MSB:`SSC_SRC_LSB] != src_sel;
    endsequence
    sequence s_setting_write;
        wr_acc && paddr == `SSC_OFF_SETTING;
    endsequence

    a_src_mrst: assert property (@(posedge pclk) disable iff (!presetn)
        s_src_change |=> master_reset ##1 !master_reset && !clock_valid)
        else $error("source change without master reset");
    a_disp_id: assert property (@(posedge pclk) disable iff (!presetn)
        s_setting_write |-> ##2 display_id == $past(pwdata[`SSC_SRC_MSB:`SSC_SRC_LSB], 2))
        else $error("display identifier does not follow source");
    a_disp_err: assert property (@(posedge pclk) disable iff (!presetn)
        s_setting_write ##2 (display_id == 4'hD || display_id == 4'hE || display_id == 4'hF) |-> display_err)
        else $error("unassigned code without error indication");
    a_leap_invalid: assert property (@(posedge pclk) disable iff (!presetn)
        leap_stb |=> !clock_valid && status_dash)
        else $error("leap did not invalidate clock status");
    a_leap_err_dual: assert property (@(posedge pclk) disable iff (!presetn)
        leap_stb && is_dual && !master_reset |=> leap_error)
        else $error("leap error missing in dual-source mode");
    a_leap_err_other: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(leap_error) |-> $past(leap_stb) && $past(is_dual))
        else $error("leap error raised outside dual-source mode");
endmodule
`default_nettype wire

// ===== rtl/ssc_cfg.svh
`ifndef SSC_CFG_SVH
`define SSC_CFG_SVH
// register byte offsets
`define SSC_OFF_SETTING 8'h00
`define SSC_OFF_STATUS 8'h04
`define SSC_OFF_INT_STAT 8'h08
`define SSC_OFF_INT_MASK 8'h0C
// setting byte fields
`define SSC_SETTING_W 8
`define SSC_SETTING_RST 8'h00
`define SSC_BIT_POLICY 6
`define SSC_BIT_OVERRIDE 5
`define SSC_BIT_LEAP_EN 4
`define SSC_SRC_MSB 3
`define SSC_SRC_LSB 0
// status register fields
`define SSC_ST_VALID 0
`define SSC_ST_LEAP_ERR 1
`define SSC_ST_DST_INT 2
`define SSC_ST_DISP_ERR 3
`define SSC_ST_SRC_LSB 4
`define SSC_ST_SRC_MSB 7
`define SSC_ST_SRC_OK 8
// interrupt status bits
`define SSC_INT_W 4
`define SSC_INT_RST 4'h0
`define SSC_INT_LEAP 0
`define SSC_INT_MRST 1
`define SSC_INT_LOST 2
`define SSC_INT_DST 3
// source codes that have an assigned mode
`define SSC_VALID_CODES 16'h1FFF
// largest accepted resync difference, in seconds
`define SSC_LEAP_MAX_SEC 32'h0000_0001
`endif

// ===== rtl/ssc_pkg.sv
package ssc_pkg;
    // synchronisation tracking of the leap checker
    typedef enum logic [1:0] {SSC_SYNC_INIT, SSC_SYNC_LOST, SSC_SYNC_LOCKED} ssc_sync_t;
    typedef logic [3:0] ssc_src_t;
    typedef logic [31:0] ssc_time_t;
endpackage

// ===== rtl/ssc_leap.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssc_cfg.svh"
module ssc_leap (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic restart, // master reset pulse
    input wire logic time_stb, // received time strobe
    input wire logic src_valid, // source delivers valid time
    input wire logic leap_en, // leap detection enable
    input wire ssc_pkg::ssc_time_t ext_time, // received time in seconds
    input wire ssc_pkg::ssc_time_t int_time, // internal clock in seconds
    output logic load_stb, // load internal clock
    output ssc_pkg::ssc_time_t load_time, // time to load
    output logic leap_stb, // leap above limit detected
    output logic lost_stb // synchronisation lost
);
    import ssc_pkg::*;
    ssc_sync_t state_r, state_nxt;
    logic load_nxt, leap_nxt, lost_nxt;
    ssc_time_t time_nxt, diff;

    // absolute difference between received and internal time
    assign diff = (ext_time > int_time) ? (ext_time - int_time) : (int_time - ext_time);

    // tracking and one-shot comparison
    always_comb begin
        state_nxt = state_r;
        load_nxt = 1'b0;
        leap_nxt = 1'b0;
        lost_nxt = 1'b0;
        time_nxt = load_time;
        if (restart) begin
            state_nxt = SSC_SYNC_INIT;
        end else if (time_stb && src_valid) begin
            load_nxt = 1'b1;
            time_nxt = ext_time;
            state_nxt = SSC_SYNC_LOCKED;
            unique case (state_r)
                SSC_SYNC_LOST: leap_nxt = leap_en && (diff > `SSC_LEAP_MAX_SEC);
                SSC_SYNC_INIT, SSC_SYNC_LOCKED: leap_nxt = 1'b0;
            endcase
        end else if (!src_valid && state_r == SSC_SYNC_LOCKED) begin
            state_nxt = SSC_SYNC_LOST;
            lost_nxt = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= SSC_SYNC_INIT;
            load_stb <= 1'b0;
            leap_stb <= 1'b0;
            lost_stb <= 1'b0;
            load_time <= 32'h0000_0000;
        end else begin
            state_r <= state_nxt;
            load_stb <= load_nxt;
            leap_stb <= leap_nxt;
            lost_stb <= lost_nxt;
            load_time <= time_nxt;
        end
    end

    a_load_direct: assert property (@(posedge pclk) disable iff (!presetn)
        time_stb && src_valid && !leap_en && !restart |=> load_stb && !leap_stb && load_time == $past(ext_time))
        else $error("received time not taken directly");
    a_load_leap: assert property (@(posedge pclk) disable iff (!presetn)
        time_stb && src_valid && leap_en && !restart |=> load_stb && load_time == $past(ext_time))
        else $error("clock not overwritten under leap detection");
    a_leap_once: assert property (@(posedge pclk) disable iff (!presetn)
        time_stb && state_r != SSC_SYNC_LOST |=> !leap_stb)
        else $error("leap checked outside first resync");
endmodule
`default_nettype wire

// ===== rtl/ssc_dst.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssc_cfg.svh"
module ssc_dst (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic policy, // fall back to internal when source lost
    input wire logic override, // internal times only
    input wire logic satnav, // satellite source selected
    input wire logic src_valid, // source delivers valid time
    input wire logic ext_chg_stb, // changeover announced by source
    input wire logic int_chg_stb, // internal changeover time reached
    output logic use_internal, // internal times in force
    output logic apply_stb // perform changeover now
);
    logic use_int_nxt, apply_nxt;

    // choose changeover origin, then pass only that origin's strobe
    always_comb begin
        use_int_nxt = override || satnav || (policy && !src_valid);
        apply_nxt = use_int_nxt ? int_chg_stb : ext_chg_stb;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            use_internal <= 1'b0;
            apply_stb <= 1'b0;
        end else begin
            use_internal <= use_int_nxt;
            apply_stb <= apply_nxt;
        end
    end

    a_ext_only: assert property (@(posedge pclk) disable iff (!presetn)
        !policy && !override && !satnav && int_chg_stb && !ext_chg_stb |=> !apply_stb && !use_internal)
        else $error("internal changeover used in external-only mode");
    a_fallback: assert property (@(posedge pclk) disable iff (!presetn)
        policy && !override && !satnav && !src_valid && int_chg_stb |=> apply_stb && use_internal)
        else $error("no internal fallback with source lost");
    a_override: assert property (@(posedge pclk) disable iff (!presetn)
        override && ext_chg_stb && !int_chg_stb |=> !apply_stb && use_internal)
        else $error("source changeover not discarded");
    a_satnav_int: assert property (@(posedge pclk) disable iff (!presetn)
        satnav |=> use_internal)
        else $error("satellite source without internal changeover");
endmodule
`default_nettype wire

// ===== tb/ssc_src_model.sv
`timescale 1ns/1ps
`default_nettype none
// stand-in for the external time source
module ssc_src_model (
    output logic src_valid, // source delivers valid time
    output logic time_stb, // received time strobe
    output ssc_pkg::ssc_time_t ext_time, // received time
    output logic ext_chg_stb, // changeover announcement
    input wire logic pclk // system clock
);
    import ssc_pkg::*;
    // quiet source at start, bus holds a pattern that no check expects
    initial begin
        src_valid = 1'h0;
        time_stb = 1'h0;
        ext_time = 32'h5A5A_A5A5;
        ext_chg_stb = 1'h0;
    end
    // validity is a level the source keeps until it changes its mind
    task automatic set_valid(input logic v);
        @(posedge pclk);
        src_valid <= v;
    endtask
    // time is only meaningful with its strobe; afterwards the bus shows the inverse so stale data cannot pass
    task automatic send_time(input ssc_time_t t);
        @(posedge pclk);
        time_stb <= 1'h1;
        ext_time <= t;
        @(posedge pclk);
        time_stb <= 1'h0;
        ext_time <= ~t;
    endtask
    // one-cycle changeover announcement
    task automatic announce();
        @(posedge pclk);
        ext_chg_stb <= 1'h1;
        @(posedge pclk);
        ext_chg_stb <= 1'h0;
    endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssc_cfg.svh"
module tb;
    import ssc_pkg::*;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, src_valid, time_stb, ext_chg_stb, clock_load, dst_apply, dst_internal;
    logic clock_valid, status_dash, leap_error, display_err, master_reset, irq;
    logic int_chg_stb = 1'h0;
    ssc_time_t ext_time, clock_load_time;
    ssc_time_t int_time = 32'h0;
    ssc_src_t display_id;
    int err_count = 0;
    int n_checks = 0;
    logic [31:0] rd;
    logic er;

    // clock at 100 MHz
    initial begin
        forever #5 pclk = ~pclk;
    end

    ssc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .src_valid(src_valid), .time_stb(time_stb), .ext_time(ext_time), .int_time(int_time),
        .ext_chg_stb(ext_chg_stb), .int_chg_stb(int_chg_stb), .clock_load(clock_load),
        .clock_load_time(clock_load_time), .dst_apply(dst_apply), .dst_internal(dst_internal),
        .clock_valid(clock_valid), .status_dash(status_dash), .leap_error(leap_error),
        .display_id(display_id), .display_err(display_err), .master_reset(master_reset), .irq(irq));

    ssc_src_model src (.src_valid(src_valid), .time_stb(time_stb), .ext_time(ext_time),
        .ext_chg_stb(ext_chg_stb), .pclk(pclk));

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer; pready, read data and error are taken at the rising edge that samples pready high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (n >= 20) begin
            err_count++;
            $display("CHECK FAILED pready expected 1 seen 0");
            tally_and_finish();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    // time delivery, load one cycle later, status one cycle after that
    task automatic sync(input ssc_time_t t, input ssc_time_t it, input logic lv, input logic le);
        @(posedge pclk);
        int_time <= it;
        src.send_time(t);
        @(negedge pclk);
        chk("clock_load", 1'h1, clock_load);
        chk("clock_load_time", t, clock_load_time);
        @(negedge pclk);
        chk("clock_valid", lv, clock_valid);
        chk("status_dash", !lv, status_dash);
        chk("leap_error", le, leap_error);
    endtask

    task automatic t_reset();
        chk("status_dash", 1'h1, status_dash);
        apb(0, `SSC_OFF_SETTING, 32'h0, rd, er);
        chk("setting", 32'h0, rd);
        apb(0, `SSC_OFF_INT_MASK, 32'h0, rd, er);
        chk("int_mask", 32'h0, rd);
        apb(1, `SSC_OFF_STATUS, 32'hFFFF_FFFF, rd, er);
        apb(0, `SSC_OFF_STATUS, 32'h0, rd, er);
        chk("status", 32'h0, rd);
        apb(0, 8'h10, 32'h0, rd, er);
        chk("pslverr", 1'h1, er);
        chk("unmapped read", 32'h0, rd);
    endtask

    task automatic t_source();
        apb(1, `SSC_OFF_INT_MASK, 32'h2, rd, er);
        for (int c = 1; c < 16; c++) begin
            apb(1, `SSC_OFF_SETTING, 32'(c), rd, er);
            @(negedge pclk);
            chk("master_reset", 1'h1, master_reset);
            @(negedge pclk);
            chk("master_reset end", 1'h0, master_reset);
            chk("display_id", 32'(c), display_id);
            chk("display_err", (c >= 13), display_err);
        end
        // rewriting the same code must not restart the system
        apb(1, `SSC_OFF_SETTING, 32'hF, rd, er);
        @(negedge pclk);
        chk("master_reset same", 1'h0, master_reset);
        chk("irq", 1'h1, irq);
        apb(1, `SSC_OFF_INT_MASK, 32'h0, rd, er);
        repeat (2) @(negedge pclk);
        chk("irq masked", 1'h0, irq);
        apb(0, `SSC_OFF_INT_STAT, 32'h0, rd, er);
        chk("int_stat reset bit", 1'h1, rd[1]);
        apb(1, `SSC_OFF_INT_MASK, 32'h2, rd, er);
        apb(1, `SSC_OFF_INT_STAT, 32'h2, rd, er);
        repeat (2) @(negedge pclk);
        chk("irq cleared", 1'h0, irq);
    endtask

    // every policy, override, source kind and validity combination
    task automatic t_dst();
        logic pol, ov, sn, sv, ui;
        for (int i = 0; i < 16; i++) begin
            {sn, sv, ov, pol} = 4'(i);
            ui = ov | sn | (pol & !sv);
            src.set_valid(sv);
            apb(1, `SSC_OFF_SETTING, {25'h0, pol, ov, 1'h0, (sn ? 4'h9 : 4'h1)}, rd, er);
            repeat (3) @(negedge pclk);
            chk("dst_internal", ui, dst_internal);
            if (sv) begin
                src.announce();
                @(negedge pclk);
                chk("dst_apply ext", !ui, dst_apply);
            end
            @(posedge pclk);
            int_chg_stb <= 1'h1;
            @(posedge pclk);
            int_chg_stb <= 1'h0;
            @(negedge pclk);
            chk("dst_apply int", ui, dst_apply);
        end
    endtask

    // fresh start, first sync, loss, regain with a chosen offset
    task automatic t_leap(input logic [3:0] code, input logic en, input ssc_time_t diff, input logic lv,
                          input logic le);
        apb(1, `SSC_OFF_SETTING, 32'h0, rd, er);
        apb(1, `SSC_OFF_SETTING, {27'h0, en, code}, rd, er);
        apb(1, `SSC_OFF_INT_STAT, 32'hF, rd, er);
        src.set_valid(1'h1);
        sync(32'h0000_1000, 32'h0000_0000, 1'h1, 1'h0);
        src.set_valid(1'h0);
        repeat (3) @(negedge pclk);
        src.set_valid(1'h1);
        sync(32'h0000_2000, 32'h0000_2000 - diff, lv, le);
        if (lv) begin
            sync(32'h0000_3000, 32'h0000_0000, 1'h1, 1'h0);
        end
        apb(0, `SSC_OFF_INT_STAT, 32'h0, rd, er);
        chk("leap event", !lv, rd[0]);
    endtask

    initial begin
        #500_000;
        err_count++;
        $display("CHECK FAILED run time expected done seen running");
        tally_and_finish();
    end

    // main sequence
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        @(negedge pclk);
        t_reset();
        t_source();
        t_dst();
        t_leap(4'h1, 1'h1, 32'h5, 1'h0, 1'h0);
        t_leap(4'h1, 1'h1, 32'hFFFF_FFFB, 1'h0, 1'h0);
        t_leap(4'hA, 1'h1, 32'h5, 1'h0, 1'h1);
        t_leap(4'h9, 1'h1, 32'h5, 1'h0, 1'h1);
        t_leap(4'h1, 1'h0, 32'h5, 1'h1, 1'h0);
        t_leap(4'h1, 1'h1, 32'h1, 1'h1, 1'h0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
